// ---- core/sgt_cfg.svh ----
// Constants for the stepped gain tracker
`ifndef SGT_CFG_SVH
`define SGT_CFG_SVH
// Control level width and step count
`define SGT_LVL_W 8
`define SGT_STEP_W 5
`define SGT_NSTEPS 32
// Hysteresis below each rising trip point, in level codes
`define SGT_HYST 8'h04
// Line path sits this many steps below its own table step, so three or four below the speaker path at zero offset
`define SGT_LINE_DROP 5'h04
// Slow clock and update cadence
`define SGT_SYS_HZ 20000000
`define SGT_SLOW_HZ 60
`define SGT_SLOW_DIV (`SGT_SYS_HZ / `SGT_SLOW_HZ)
`define SGT_TICKS_PER_STEP 4
`define SGT_STEP_MS 67
`define SGT_RESET_STEP 5'h00
`endif

// ---- core/sgt_pkg.sv ----
// Types for the stepped gain tracker
package sgt_pkg;
   typedef logic [7:0] sgt_level_t;
   typedef logic [4:0] sgt_step_t;
   typedef struct packed {
      sgt_level_t volume;
      sgt_level_t offset;
      sgt_level_t ceiling;
      sgt_level_t reference;
   } sgt_ctrl_s;
   typedef struct packed {
      sgt_step_t speaker;
      sgt_step_t line;
   } sgt_gain_s;
   typedef enum logic [1:0] {SGT_IDLE, SGT_UP, SGT_DOWN} sgt_dir_e;
endpackage

// ---- core/sgt_top.sv ----
// Stepped gain tracker: control levels to speaker and line gain steps
// How it works
// - Speaker step follows volume relative to reference only.
// - Rising trips use full thresholds; falling trips sit lower by hysteresis.
// - Selection is monotonic and holds steady near a boundary.
// - Every fourth slow-clock cycle applied gain moves one step toward target.
// - At zero offset the line gain sits three or four steps below speaker gain, floored at zero.
// - Line volume value is volume minus offset, floored at zero.
// - Ceiling input caps the line gain.
// - Line value maps to a step through its own table.
`timescale 1ns/1ns
`include "sgt_cfg.svh"
module sgt_top #(
   parameter int SLOW_DIV = `SGT_SLOW_DIV,
   parameter int TICKS = `SGT_TICKS_PER_STEP
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Quantized control levels from outside the clock domain
   input wire sgt_pkg::sgt_ctrl_s ctrl,
   // Applied gain steps
   output sgt_pkg::sgt_gain_s gain,
   // Target speaker step and update tick
   output sgt_pkg::sgt_step_t speaker_target,
   output logic update_tick
);
   import sgt_pkg::*;

   // ************************************************
   // Input synchronisers
   // ************************************************
   sgt_ctrl_s meta_q;
   sgt_ctrl_s sync_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= ctrl;
         sync_q <= meta_q;
      end
   end

   // ************************************************
   // Word capture
   // ************************************************
   // Bits of one level may cross on different edges and show a level nobody drove
   // Word taken only after two equal synced samples
   // Costs two cycles of latency, far below the update cadence
   sgt_ctrl_s prev_q;
   sgt_ctrl_s ctrl_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= '0;
      end else begin
         prev_q <= sync_q;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= '0;
      end else if (sync_q == prev_q) begin
         ctrl_q <= prev_q;
      end
   end

   // ************************************************
   // Level normalisation
   // ************************************************
   // Scales a level to a fraction of the reference, 0..255
   function automatic sgt_level_t rel(input sgt_level_t v, input sgt_level_t r);
      logic [15:0] num;
      logic [15:0] q;
      num = {v, 8'h00};
      if (r == 8'h00) begin
         q = 16'h0000;
      end else if (v >= r) begin
         q = 16'h00ff;
      end else begin
         q = num / {8'h00, r};
      end
      return q[7:0];
   endfunction

   // Rising trip for step s: evenly spaced; step 0 has none
   function automatic sgt_level_t rise_trip(input sgt_step_t s);
      return {s, 3'h0};
   endfunction

   // Table for the line path, offset by half a step from the speaker table
   function automatic sgt_step_t line_lookup(input sgt_level_t v);
      logic [7:0] t;
      t = (v > 8'hfb) ? 8'hff : v + 8'h04;
      return t[7:3];
   endfunction

   sgt_level_t vol_rel;
   sgt_level_t off_rel;
   sgt_level_t cap_rel;
   assign vol_rel = rel(ctrl_q.volume, ctrl_q.reference);
   assign off_rel = rel(ctrl_q.offset, ctrl_q.reference);
   assign cap_rel = rel(ctrl_q.ceiling, ctrl_q.reference);

   // ************************************************
   // Speaker target with hysteresis
   // ************************************************
   // One step per cycle; a large move settles within 31 cycles, far faster than updates
   sgt_step_t target_q;
   sgt_step_t target_d;
   always_comb begin
      target_d = target_q;
      if (target_q != 5'h1f && vol_rel >= rise_trip(target_q + 5'h01)) begin
         target_d = target_q + 5'h01;
      end else if (target_q != 5'h00 && vol_rel < rise_trip(target_q) - `SGT_HYST) begin
         target_d = target_q - 5'h01;
      end
   end
   // Dead band between the two trips keeps the target from chattering
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         target_q <= `SGT_RESET_STEP;
      end else begin
         target_q <= target_d;
      end
   end

   // ************************************************
   // Slow clock and update tick
   // ************************************************
   logic [$clog2(SLOW_DIV)-1:0] div_q;
   logic [$clog2(TICKS)-1:0] tick_cnt_q;
   logic slow_pulse;
   logic tick_q;
   assign slow_pulse = (div_q == ($clog2(SLOW_DIV))'(SLOW_DIV - 1));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= '0;
      end else if (slow_pulse) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (slow_pulse) begin
            if (tick_cnt_q == ($clog2(TICKS))'(TICKS - 1)) begin
               tick_cnt_q <= '0;
               tick_q <= 1'b1;
            end else begin
               tick_cnt_q <= tick_cnt_q + 1'b1;
            end
         end
      end
   end

   // ************************************************
   // Applied speaker step
   // ************************************************
   sgt_step_t spk_q;
   sgt_dir_e dir;
   always_comb begin
      if (target_q > spk_q) begin
         dir = SGT_UP;
      end else if (target_q < spk_q) begin
         dir = SGT_DOWN;
      end else begin
         dir = SGT_IDLE;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         spk_q <= `SGT_RESET_STEP;
      end else if (tick_q) begin
         case (dir)
            SGT_UP: spk_q <= spk_q + 5'h01;
            SGT_DOWN: spk_q <= spk_q - 5'h01;
            SGT_IDLE: spk_q <= spk_q;
            default: spk_q <= spk_q;
         endcase
      end
   end

   // ************************************************
   // Line output path
   // ************************************************
   sgt_level_t line_volume_value;
   sgt_step_t line_raw;
   sgt_step_t line_cap;
   sgt_step_t line_tgt;
   sgt_step_t line_q;
   assign line_volume_value = (vol_rel > off_rel) ? vol_rel - off_rel : 8'h00;
   always_comb begin
      line_raw = line_lookup(line_volume_value);
      line_raw = (line_raw > `SGT_LINE_DROP) ? line_raw - `SGT_LINE_DROP : 5'h00;
      line_cap = cap_rel[7:3];
      line_tgt = (line_raw > line_cap) ? line_cap : line_raw;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         line_q <= `SGT_RESET_STEP;
      end else if (tick_q) begin
         if (line_tgt > line_q) begin
            line_q <= line_q + 5'h01;
         end else if (line_tgt < line_q) begin
            line_q <= line_q - 5'h01;
         end
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign gain = {spk_q, line_q};
   assign speaker_target = target_q;
   assign update_tick = tick_q;
endmodule // sgt_top

// ---- dv/sgt_top_sva.sv ----
// Port checker for the stepped gain tracker
`timescale 1ns/1ns
module sgt_chk #(parameter int SLOW_DIV = 333333, parameter int TICKS = 4) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Watched outputs
   input wire sgt_pkg::sgt_gain_s gain,
   input wire sgt_pkg::sgt_step_t speaker_target,
   input wire logic update_tick
);
   import sgt_pkg::*;
   logic [31:0] gap_q;
   logic seen_q;
   // First tick has no earlier tick to measure from
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_q <= 32'h0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= update_tick ? 32'h0 : gap_q + 32'h1;
         seen_q <= seen_q | update_tick;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_rst; $rose(nrst) |-> gain == '0 && speaker_target == '0; endproperty
   a_rst: assert property (p_rst) else $error("not lowest after reset");
   property p_on_tick; $changed(gain) |-> $past(update_tick); endproperty
   a_on_tick: assert property (p_on_tick) else $error("gain moved off tick");
   property p_spk_one; $changed(gain.speaker) |-> gain.speaker == $past(gain.speaker) + 5'h01
      || gain.speaker == $past(gain.speaker) - 5'h01; endproperty
   a_spk_one: assert property (p_spk_one) else $error("speaker jump");
   property p_line_one; $changed(gain.line) |-> gain.line == $past(gain.line) + 5'h01
      || gain.line == $past(gain.line) - 5'h01; endproperty
   a_line_one: assert property (p_line_one) else $error("line jump");
   property p_toward; $changed(gain.speaker) |-> (gain.speaker > $past(gain.speaker))
      == ($past(speaker_target) > $past(gain.speaker)); endproperty
   a_toward: assert property (p_toward) else $error("step away from target");
   property p_tgt_one; $changed(speaker_target) |-> speaker_target == $past(speaker_target)
      + 5'h01 || speaker_target == $past(speaker_target) - 5'h01; endproperty
   a_tgt_one: assert property (p_tgt_one) else $error("target jump");
   property p_pulse; update_tick |=> !update_tick [*8]; endproperty
   a_pulse: assert property (p_pulse) else $error("tick too long");
   property p_period; update_tick && seen_q |-> gap_q == 32'(SLOW_DIV * TICKS - 1); endproperty
   a_period: assert property (p_period) else $error("tick period");
endmodule // sgt_chk
bind sgt_top sgt_chk #(.SLOW_DIV(SLOW_DIV), .TICKS(TICKS)) chk_u (.clk(clk), .nrst(nrst),
   .gain(gain), .speaker_target(speaker_target), .update_tick(update_tick));

// ---- dv/sgt_dac.sv ----
// Control-level source model: a DAC with full-scale reference, or half-scale while half is set
`timescale 1ns/1ns
module sgt_dac (
   // Requested step, direction and line levels
   input wire sgt_pkg::sgt_step_t step,
   input wire logic up,
   input wire sgt_pkg::sgt_level_t offset,
   input wire sgt_pkg::sgt_level_t ceiling,
   // Half-scale reference; every level is halved with it
   input wire logic half,
   // Levels to the tracker
   output sgt_pkg::sgt_ctrl_s ctrl
);
   import sgt_pkg::*;
   sgt_level_t code;
   // Rising table going up, lower falling table going down
   assign code = up ? {step, 3'h0} : {step, 3'h0} - 8'h04;
   assign ctrl.volume = half ? {1'b0, code[7:1]} : code;
   assign ctrl.offset = half ? {1'b0, offset[7:1]} : offset;
   assign ctrl.ceiling = half ? {1'b0, ceiling[7:1]} : ceiling;
   assign ctrl.reference = half ? 8'h80 : 8'hff;
endmodule // sgt_dac

// ---- dv/tb_stepped_gain_tracker.sv ----
// Self-checking bench for the stepped gain tracker
`timescale 1ns/1ns
module tb_stepped_gain_tracker;
   import sgt_pkg::*;
   localparam int SIM_DIV = 4;
   localparam int SIM_TICKS = 4;
   logic clk = 1'b0;
   logic half = 1'b0;
   logic nrst = 1'b0;
   sgt_step_t step = 5'h00;
   logic up = 1'b1;
   sgt_level_t offset = 8'h00;
   sgt_level_t ceiling = 8'hff;
   sgt_ctrl_s ctrl;
   sgt_gain_s gain;
   sgt_step_t speaker_target;
   logic update_tick;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   sgt_dac dac_u (.step(step), .up(up), .offset(offset), .ceiling(ceiling), .half(half),
      .ctrl(ctrl));
   sgt_top #(.SLOW_DIV(SIM_DIV), .TICKS(SIM_TICKS)) dut_u (.clk(clk), .nrst(nrst), .ctrl(ctrl),
      .gain(gain), .speaker_target(speaker_target), .update_tick(update_tick));
   always #25 clk = ~clk;
   task automatic complete_run();
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic drive(input sgt_step_t s, input logic u, input sgt_level_t o,
         input sgt_level_t c);
      @(posedge clk);
      step <= s;
      up <= u;
      offset <= o;
      ceiling <= c;
   endtask
   // Extra ticks after arrival catch toggling near a boundary
   task automatic settle(input sgt_step_t s, input sgt_step_t l);
      int n = 0;
      // Falling edge keeps samples clear of the launching edge
      while (gain !== {s, l} && n < 1500) begin
         @(negedge clk);
         n++;
      end
      repeat (40) @(negedge clk);
      n_tests++;
      if (gain !== {s, l} || speaker_target !== s) begin
         n_fail++;
         $display("BAD %0t gain %h target %h", $time, gain, speaker_target);
      end
   endtask
   task automatic t_ramp();
      settle(5'h00, 5'h00);
      drive(5'h1f, 1'b1, 8'h00, 8'hff);
      settle(5'h1f, 5'h1b);
   endtask
   task automatic t_line();
      drive(5'h1f, 1'b1, 8'h40, 8'hff);
      settle(5'h1f, 5'h13);
      drive(5'h1f, 1'b1, 8'h00, 8'h50);
      settle(5'h1f, 5'h0a);
      drive(5'h1f, 1'b1, 8'hff, 8'hff);
      settle(5'h1f, 5'h00);
   endtask
   task automatic t_hyst();
      drive(5'h10, 1'b0, 8'h00, 8'hff);
      settle(5'h10, 5'h0c);
      drive(5'h10, 1'b1, 8'h00, 8'hff);
      settle(5'h10, 5'h0c);
      drive(5'h0f, 1'b0, 8'h00, 8'hff);
      settle(5'h0f, 5'h0b);
      drive(5'h10, 1'b0, 8'h00, 8'hff);
      settle(5'h0f, 5'h0c);
      drive(5'h10, 1'b1, 8'h00, 8'hff);
      settle(5'h10, 5'h0c);
   endtask
   // Half reference with halved levels must give the same steps
   task automatic t_ref();
      @(posedge clk);
      half <= 1'b1;
      settle(5'h10, 5'h0c);
      drive(5'h1f, 1'b1, 8'h40, 8'hff);
      settle(5'h1f, 5'h13);
      drive(5'h1f, 1'b1, 8'h00, 8'h50);
      settle(5'h1f, 5'h0a);
   endtask
   // Reset in mid-run from a high step
   task automatic t_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      n_tests++;
      if (gain !== 10'h000 || speaker_target !== 5'h00) begin
         n_fail++;
         $display("BAD %0t reset gain %h target %h", $time, gain, speaker_target);
      end
      @(posedge clk);
      nrst <= 1'b1;
      settle(5'h1f, 5'h0a);
   endtask
   // One tick per SIM_DIV * SIM_TICKS cycles
   task automatic t_tick();
      int seen = 0;
      repeat (10 * SIM_DIV * SIM_TICKS) begin
         @(negedge clk);
         if (update_tick === 1'b1) begin
            seen++;
         end
      end
      n_tests++;
      if (seen != 10) begin
         n_fail++;
         $display("BAD %0t tick count %0d", $time, seen);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_ramp();
      t_line();
      t_hyst();
      t_ref();
      t_reset();
      t_tick();
      complete_run();
   end
endmodule // tb_stepped_gain_tracker
